//--- bench/cpu_pointer_segment_regs_tb.sv
// Self-checking testbench for the pointer, segment and general register block
`timescale 1ns/1ns
`default_nettype none
`include "seg_regs_defs.svh"
module cpu_pointer_segment_regs_tb;
    import seg_regs_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, qt, qf, tl, seg_write = 1'b0, override_valid = 1'b0;
    logic [15:0] tt, seg_write_data = 16'h0, gpr_write_data = 16'h0;
    logic [1:0] seg_write_sel = 2'h0, gpr_write_sel = 2'h0, gpr_read_sel = 2'h0;
    gpr_write_t gpr_write_mode = GW_NONE;
    acc_kind_t acc_kind = ACC_FETCH;
    seg_sel_t override_seg = SEG_CODE, used_seg;
    logic [15:0] eff = 16'h8001, stp = 16'h0ff2, src = 16'h1233, dst = 16'hfffe;
    logic [15:0] ep, pf, cs, ss, d0, d1, grw, aw, bw, cw, dw;
    logic [7:0] grl, grh;
    logic [19:0] addr;
    logic [15:0] segv [4] = '{16'h1000, 16'h2345, 16'hfff0, 16'habcd};
    int bad_count = 0, checks = 0;

    always #4 ref_clk = ~ref_clk;

    exec_unit_model partner (.ref_clk(ref_clk), .queue_take(qt), .queue_fetch(qf),
        .transfer_load(tl), .transfer_target(tt));
    cpu_pointer_segment_regs DUT (.ref_clk(ref_clk), .resetn(resetn), .queue_take(qt),
        .queue_fetch(qf), .transfer_load(tl), .transfer_target(tt),
        .seg_write_sel(seg_write_sel), .seg_write(seg_write), .seg_write_data(seg_write_data),
        .gpr_write_sel(gpr_write_sel), .gpr_write_mode(gpr_write_mode),
        .gpr_write_data(gpr_write_data), .gpr_read_sel(gpr_read_sel), .acc_kind(acc_kind),
        .override_valid(override_valid), .override_seg(override_seg), .effective_offset(eff),
        .stack_top_pointer(stp), .source_index(src), .dest_index(dst), .execute_pointer(ep),
        .prefetch_offset(pf), .code_segment_base(cs), .stack_segment_base(ss),
        .data_segment_zero(d0), .data_segment_one(d1), .gpr_read_word(grw),
        .gpr_read_low(grl), .gpr_read_high(grh), .accumulator_word(aw), .base_word(bw),
        .count_word(cw), .data_word(dw), .used_seg(used_seg), .mem_address(addr));

    // Wide enough for every packed group of outputs compared at once
    task automatic cmp_val(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_seg(input seg_sel_t got, input seg_sel_t exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic t_reset();
        @(negedge ref_clk);
        resetn = 1'b0;
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        cmp_val({ep, pf, cs, ss}, {`PTR_RESET, `PTR_RESET, `SEG_RESET, `SEG_RESET});
        cmp_val({d0, d1, aw, bw, cw, dw}, {`SEG_RESET, `SEG_RESET, {4{`GPR_RESET}}});
        $display("test reset done");
    endtask

    task automatic t_pointers();
        partner.issue(1'b0, 1'b0, 1'b1, 16'h0100, 1);
        cmp_val({ep, pf}, {16'h0100, 16'h0100});
        cmp_val(pf, 20'h0100);
        partner.issue(1'b0, 1'b1, 1'b0, 16'h0, 3);
        cmp_val({4'h0, pf, ep}, {4'h0, 16'h0103, 16'h0100});
        partner.issue(1'b1, 1'b0, 1'b0, 16'h0, 2);
        cmp_val({pf, ep}, {16'h0103, 16'h0102});
        partner.issue(1'b1, 1'b1, 1'b0, 16'h0, 1);
        cmp_val({pf, ep}, {16'h0104, 16'h0103});
        partner.issue(1'b1, 1'b1, 1'b1, 16'hffff, 1);
        cmp_val({pf, ep}, {16'hffff, 16'hffff});
        partner.issue(1'b1, 1'b1, 1'b0, 16'h0, 1);
        cmp_val({pf, ep}, 32'h0);
        $display("test pointers done");
    endtask

    task automatic t_address();
        seg_sel_t es;
        logic [15:0] off;
        for (int s = 0; s < 4; s++) begin
            @(negedge ref_clk);
            seg_write = 1'b1;
            seg_write_sel = 2'(s);
            seg_write_data = segv[s];
        end
        @(negedge ref_clk);
        seg_write = 1'b0;
        cmp_val({cs, ss, d0, d1}, {segv[0], segv[1], segv[2], segv[3]});
        partner.issue(1'b0, 1'b0, 1'b1, 16'hfff8, 1);
        for (int v = 0; v < 2; v++)
            for (int o = 0; o < 4; o++)
                for (int k = 0; k < 7; k++) begin
                    @(negedge ref_clk);
                    acc_kind = acc_kind_t'(k);
                    override_valid = 1'(v);
                    override_seg = seg_sel_t'(o);
                    #1;
                    es = (k == 0) ? SEG_CODE : (k == 1 || k == 2) ? SEG_STACK :
                         (k == 5) ? SEG_DATA1 : SEG_DATA0;
                    if (v == 1 && k >= 2 && k <= 4)
                        es = seg_sel_t'(o);
                    // Fetch offset is the pointer value loaded just above
                    off = (k == 0) ? 16'hfff8 : (k == 1) ? stp : (k == 4) ? src :
                          (k == 5) ? dst : eff;
                    if (k == 6) begin
                        cmp_val(addr, {4'h0, eff});
                    end else begin
                        cmp_seg(used_seg, es);
                        cmp_val(addr, 20'({segv[es], 4'h0} + {4'h0, off}));
                    end
                end
        $display("test address done");
    endtask

    task automatic gw(input int sel, input gpr_write_t m, input logic [15:0] d);
        @(negedge ref_clk);
        gpr_write_sel = 2'(sel);
        gpr_write_mode = m;
        gpr_write_data = d;
        @(negedge ref_clk);
        gpr_write_mode = GW_NONE;
    endtask

    task automatic t_gpr();
        logic [15:0] e [4] = '{16'h1111, 16'h22ab, 16'hcd33, 16'h4444};
        for (int i = 0; i < 4; i++)
            gw(i, GW_WORD, 16'h1111 * 16'(i + 1));
        // Byte data always rides in the low eight bits of the write data
        gw(1, GW_LOW, 16'h77ab);
        gw(2, GW_HIGH, 16'h88cd);
        gw(3, GW_NONE, 16'hffff);
        cmp_val({aw, bw}, {e[0], e[1]});
        cmp_val({cw, dw}, {e[2], e[3]});
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            gpr_read_sel = 2'(i);
            #1;
            cmp_val({grw, grh, grl}, {e[i], e[i]});
        end
        $display("test registers done");
    endtask

    task automatic end_sim();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_sim();
    end

    initial begin
        t_reset();
        t_pointers();
        t_address();
        t_gpr();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire

//--- bench/exec_unit_model.sv
// Behavioural model of the execution unit and bus unit that drive the pointer strobes
`timescale 1ns/1ns
`default_nettype none
module exec_unit_model (
    input wire logic ref_clk,
    output logic queue_take,
    output logic queue_fetch,
    output logic transfer_load,
    output logic [15:0] transfer_target
);
    initial begin
        queue_take = 1'b0;
        queue_fetch = 1'b0;
        transfer_load = 1'b0;
        transfer_target = 16'h5a5a;
    end
    // Strobes held for n edges, so n above one gives back-to-back requests
    task automatic issue(input logic take, input logic fetch, input logic load,
                         input logic [15:0] target, input int n);
        @(negedge ref_clk);
        queue_take = take;
        queue_fetch = fetch;
        transfer_load = load;
        transfer_target = target;
        repeat (n) @(negedge ref_clk);
        queue_take = 1'b0;
        queue_fetch = 1'b0;
        transfer_load = 1'b0;
        // An idle target carries no meaning, so it must not echo the last value
        transfer_target = ~target;
    endtask
endmodule
`default_nettype wire

//--- logic/cpu_pointer_segment_regs.sv
// Execution/prefetch pointers, segment and general registers, address former
// Contract
// - The execution pointer is 16 bits and counts up on each take from the queue.
// - Branch, call, return, break and interrupt load a new execution pointer.
// - A separate 16-bit prefetch pointer holds the next fetch offset.
// - The prefetch pointer counts up on each queue fetch, independently of execution.
// - On any control transfer the prefetch pointer takes the same value as the execution pointer.
// - Memory addresses are a 20-bit segment base plus a 16-bit offset.
// - I/O addresses are the offset alone with no segment.
// - Fetch uses the code segment and stack uses the stack segment, never overridden.
// - Frame-based operands default to stack, others to data zero, both overridable.
// - Source index accesses default to data zero and may be overridden.
// - Destination index accesses always use data one.
// - Four 16-bit general registers, each also reachable as two bytes.
`timescale 1ns/1ns
`default_nettype none
`include "seg_regs_defs.svh"
module cpu_pointer_segment_regs (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic queue_take,
    input wire logic queue_fetch,
    input wire logic transfer_load,
    input wire logic [15:0] transfer_target,
    input wire logic [1:0] seg_write_sel,
    input wire logic seg_write,
    input wire logic [15:0] seg_write_data,
    input wire logic [1:0] gpr_write_sel,
    input wire seg_regs_pkg::gpr_write_t gpr_write_mode,
    input wire logic [15:0] gpr_write_data,
    input wire logic [1:0] gpr_read_sel,
    input wire seg_regs_pkg::acc_kind_t acc_kind,
    input wire logic override_valid,
    input wire seg_regs_pkg::seg_sel_t override_seg,
    input wire logic [15:0] effective_offset,
    input wire logic [15:0] stack_top_pointer,
    input wire logic [15:0] source_index,
    input wire logic [15:0] dest_index,
    output logic [15:0] execute_pointer,
    output logic [15:0] prefetch_offset,
    output logic [15:0] code_segment_base,
    output logic [15:0] stack_segment_base,
    output logic [15:0] data_segment_zero,
    output logic [15:0] data_segment_one,
    output logic [15:0] gpr_read_word,
    output logic [7:0] gpr_read_low,
    output logic [7:0] gpr_read_high,
    output logic [15:0] accumulator_word,
    output logic [15:0] base_word,
    output logic [15:0] count_word,
    output logic [15:0] data_word,
    output seg_regs_pkg::seg_sel_t used_seg,
    output logic [`ADDR_W-1:0] mem_address
);
    import seg_regs_pkg::*;

    logic [15:0] next_execute_pointer;
    logic [15:0] next_prefetch_offset;
    logic [15:0] segs [4];
    logic [15:0] next_segs [4];
    logic [15:0] gprs [`NUM_GPR];
    logic [15:0] next_gprs [`NUM_GPR];
    logic [15:0] acc_offset;

    // Pointer group: a control transfer outranks counting on both pointers
    always_comb begin
        next_execute_pointer = execute_pointer;
        next_prefetch_offset = prefetch_offset;
        if (transfer_load) begin
            next_execute_pointer = transfer_target;
            next_prefetch_offset = transfer_target;
        end else begin
            if (queue_take) begin
                next_execute_pointer = execute_pointer + 16'h0001;
            end
            if (queue_fetch) begin
                next_prefetch_offset = prefetch_offset + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            execute_pointer <= `PTR_RESET;
            prefetch_offset <= `PTR_RESET;
        end else begin
            execute_pointer <= next_execute_pointer;
            prefetch_offset <= next_prefetch_offset;
        end
    end

    // Segment and general register groups
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_regs
            always_comb begin
                next_segs[gi] = segs[gi];
                if (seg_write && seg_write_sel == 2'(gi)) begin
                    next_segs[gi] = seg_write_data;
                end
                next_gprs[gi] = gprs[gi];
                if (gpr_write_sel == 2'(gi)) begin
                    case (gpr_write_mode)
                        GW_WORD: next_gprs[gi] = gpr_write_data;
                        GW_LOW: next_gprs[gi] = {gprs[gi][15:8], gpr_write_data[7:0]};
                        GW_HIGH: next_gprs[gi] = {gpr_write_data[7:0], gprs[gi][7:0]};
                        default: next_gprs[gi] = gprs[gi];
                    endcase
                end
            end
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    segs[gi] <= `SEG_RESET;
                    gprs[gi] <= `GPR_RESET;
                end else begin
                    segs[gi] <= next_segs[gi];
                    gprs[gi] <= next_gprs[gi];
                end
            end
        end
    endgenerate

    assign code_segment_base = segs[SEG_CODE];
    assign stack_segment_base = segs[SEG_STACK];
    assign data_segment_zero = segs[SEG_DATA0];
    assign data_segment_one = segs[SEG_DATA1];
    assign accumulator_word = gprs[0];
    assign base_word = gprs[1];
    assign count_word = gprs[2];
    assign data_word = gprs[3];
    assign gpr_read_word = gprs[gpr_read_sel];
    // Byte halves read out of the same word so they never disagree
    assign gpr_read_low = gprs[gpr_read_sel][7:0];
    assign gpr_read_high = gprs[gpr_read_sel][15:8];

    // Offset source per access kind; fetch always uses the prefetch pointer
    always_comb begin
        case (acc_kind)
            ACC_FETCH: acc_offset = prefetch_offset;
            ACC_STACK: acc_offset = stack_top_pointer;
            ACC_SRC_INDEX: acc_offset = source_index;
            ACC_DST_INDEX: acc_offset = dest_index;
            default: acc_offset = effective_offset;
        endcase
    end

    seg_select u_seg_select (
        .kind(acc_kind),
        .override_valid(override_valid),
        .override_seg(override_seg),
        .seg_value(segs),
        .offset(acc_offset),
        .used_seg(used_seg),
        .address(mem_address)
    );

    property p_exec_inc;
        @(posedge ref_clk) disable iff (!resetn)
        (queue_take && !transfer_load) |=> execute_pointer == $past(execute_pointer) + 16'h0001;
    endproperty
    a_exec_inc: assert property (p_exec_inc) else $error("execute pointer stuck");

    property p_exec_load;
        @(posedge ref_clk) disable iff (!resetn)
        transfer_load |=> execute_pointer == $past(transfer_target);
    endproperty
    a_exec_load: assert property (p_exec_load) else $error("pointer not loaded");

    property p_exec_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (!queue_take && !transfer_load) |=> $stable(execute_pointer);
    endproperty
    a_exec_hold: assert property (p_exec_hold) else $error("execute pointer moved");

    property p_pf_inc;
        @(posedge ref_clk) disable iff (!resetn)
        (queue_fetch && !transfer_load) |=> prefetch_offset == $past(prefetch_offset) + 16'h0001;
    endproperty
    a_pf_inc: assert property (p_pf_inc) else $error("prefetch pointer stuck");

    property p_pf_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (!queue_fetch && !transfer_load) |=> $stable(prefetch_offset);
    endproperty
    a_pf_hold: assert property (p_pf_hold) else $error("prefetch pointer moved");

    property p_pf_sync;
        @(posedge ref_clk) disable iff (!resetn)
        transfer_load |=> prefetch_offset == execute_pointer;
    endproperty
    a_pf_sync: assert property (p_pf_sync) else $error("pointers differ");

    property p_fetch_code;
        @(posedge ref_clk) disable iff (!resetn)
        acc_kind == ACC_FETCH |-> used_seg == SEG_CODE
            && mem_address == 20'({segs[SEG_CODE], 4'h0} + {4'h0, prefetch_offset});
    endproperty
    a_fetch_code: assert property (p_fetch_code) else $error("fetch address wrong");

    property p_stack_fixed;
        @(posedge ref_clk) disable iff (!resetn)
        acc_kind == ACC_STACK |-> used_seg == SEG_STACK;
    endproperty
    a_stack_fixed: assert property (p_stack_fixed) else $error("stack seg overridden");

    property p_dst_fixed;
        @(posedge ref_clk) disable iff (!resetn)
        acc_kind == ACC_DST_INDEX |-> used_seg == SEG_DATA1;
    endproperty
    a_dst_fixed: assert property (p_dst_fixed) else $error("dest segment wrong");

    property p_io_flat;
        @(posedge ref_clk) disable iff (!resetn)
        acc_kind == ACC_IO |-> mem_address == {4'h0, effective_offset};
    endproperty
    a_io_flat: assert property (p_io_flat) else $error("io address segmented");

    property p_frame_default;
        @(posedge ref_clk) disable iff (!resetn)
        (acc_kind == ACC_EA_FRAME && !override_valid) |-> used_seg == SEG_STACK;
    endproperty
    a_frame_default: assert property (p_frame_default) else $error("frame seg wrong");

    property p_src_override;
        @(posedge ref_clk) disable iff (!resetn)
        acc_kind == ACC_SRC_INDEX |->
            used_seg == (override_valid ? override_seg : SEG_DATA0);
    endproperty
    a_src_override: assert property (p_src_override) else $error("source seg wrong");

    // Byte writes to any register must take the low data byte and spare the other half
    property p_low_write;
        @(posedge ref_clk) disable iff (!resetn)
        gpr_write_mode == GW_LOW
            |=> gprs[$past(gpr_write_sel)][15:8] == $past(gprs[gpr_write_sel][15:8])
            && gprs[$past(gpr_write_sel)][7:0] == $past(gpr_write_data[7:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte write wrong");

    property p_high_write;
        @(posedge ref_clk) disable iff (!resetn)
        gpr_write_mode == GW_HIGH
            |=> gprs[$past(gpr_write_sel)][7:0] == $past(gprs[gpr_write_sel][7:0])
            && gprs[$past(gpr_write_sel)][15:8] == $past(gpr_write_data[7:0]);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high byte write wrong");

    c_transfer: cover property (@(posedge ref_clk) disable iff (!resetn) transfer_load);
    c_diverge: cover property (@(posedge ref_clk) disable iff (!resetn)
        queue_fetch && !queue_take ##1 prefetch_offset != execute_pointer);
    c_override: cover property (@(posedge ref_clk) disable iff (!resetn)
        acc_kind == ACC_EA_OTHER && override_valid);
    c_wrap: cover property (@(posedge ref_clk) disable iff (!resetn)
        mem_address < {4'h0, acc_offset} && acc_kind != ACC_IO);
endmodule
`default_nettype wire

//--- logic/seg_select.sv
// Default segment choice, override legality and 20-bit address forming
`timescale 1ns/1ns
`default_nettype none
`include "seg_regs_defs.svh"
module seg_select (
    input wire seg_regs_pkg::acc_kind_t kind,
    input wire logic override_valid,
    input wire seg_regs_pkg::seg_sel_t override_seg,
    input wire logic [15:0] seg_value [4],
    input wire logic [15:0] offset,
    output seg_regs_pkg::seg_sel_t used_seg,
    output logic [`ADDR_W-1:0] address
);
    import seg_regs_pkg::*;

    function automatic seg_sel_t default_seg(input acc_kind_t k);
        case (k)
            ACC_FETCH: default_seg = SEG_CODE;
            ACC_STACK, ACC_EA_FRAME: default_seg = SEG_STACK;
            ACC_DST_INDEX: default_seg = SEG_DATA1;
            default: default_seg = SEG_DATA0;
        endcase
    endfunction

    function automatic logic may_override(input acc_kind_t k);
        may_override = (k == ACC_EA_FRAME) || (k == ACC_EA_OTHER) || (k == ACC_SRC_INDEX);
    endfunction

    always_comb begin
        used_seg = (override_valid && may_override(kind)) ? override_seg : default_seg(kind);
        if (kind == ACC_IO) begin
            address = {4'h0, offset};
        end else begin
            address = {seg_value[used_seg], 4'h0} + {4'h0, offset};
        end
    end
endmodule
`default_nettype wire

//--- shared/seg_regs_defs.svh
// Constants for the pointer and segment register block
`ifndef SEG_REGS_DEFS_SVH
`define SEG_REGS_DEFS_SVH
`define PTR_RESET 16'h0000
`define SEG_RESET 16'h0000
`define GPR_RESET 16'h0000
`define SEG_SHIFT 4
`define ADDR_W 20
`define NUM_GPR 4
`endif

//--- shared/seg_regs_pkg.sv
// Types for the pointer and segment register block
`default_nettype none
`include "seg_regs_defs.svh"
package seg_regs_pkg;
    typedef enum logic [1:0] {
        SEG_CODE,
        SEG_STACK,
        SEG_DATA0,
        SEG_DATA1
    } seg_sel_t;
    typedef enum logic [2:0] {
        ACC_FETCH,
        ACC_STACK,
        ACC_EA_FRAME,
        ACC_EA_OTHER,
        ACC_SRC_INDEX,
        ACC_DST_INDEX,
        ACC_IO
    } acc_kind_t;
    typedef enum logic [1:0] {
        GW_NONE,
        GW_WORD,
        GW_LOW,
        GW_HIGH
    } gpr_write_t;
endpackage
`default_nettype wire
